// *** rtl/interrupt_source_config.sv ***
// Per-source interrupt configuration with APB registers and event interrupt.
//
// Overview of operation
// - Each source keeps its own setting of level, active state and DMA role.
// - With the DMA bit clear the level field is the interrupt priority level.
// - Level 000 blocks the source's int_req but not its status events; 001 to 111 give levels 1 to 7.
// - The DMA bit picks ordinary interrupt (0) or DMA activation trigger (1).
// - With the DMA bit set the level field names DMA channel 0 to 7.
// - Active state 00 low, 01 high, 10 falling edge, 11 rising edge.
`timescale 1ns/100ps
module interrupt_source_config
  import source_config_pkg::*;
(
  input  wire logic                               clock,
  input  wire logic                               resetn,
  input  source_config_pkg::apb_req_t             apb_req,
  output source_config_pkg::apb_rsp_t             apb_rsp,
  input  wire logic [source_config_pkg::NUM_SRC-1:1] external_request,
  output logic [source_config_pkg::NUM_SRC-1:0]   int_req,
  output logic [source_config_pkg::NUM_SRC-1:0][2:0] int_level,
  output logic [source_config_pkg::NUM_CHAN-1:0]  dma_req,
  output logic                                    irq
);

  import source_config_pkg::*;

  typedef struct packed {
    src_cfg_t [NUM_SRC-1:0] cfg;
    logic                   sw_set;
    logic [NUM_SRC-1:0]     status;
    logic [NUM_SRC-1:0]     mask;
    logic [NUM_SRC-1:0]     act_prev;
    logic [31:0]            rdata;
  } state_t;

  state_t                            st_q;
  state_t                            st_d;
  logic [NUM_SRC-1:0]                active;
  logic [NUM_SRC-1:0]                event_set;
  logic [NUM_SRC-1:0][NUM_CHAN-1:0]  chan_req;
  logic                              setup_ph;
  logic                              access_ph;
  reg_sel_t                          sel;

  assign setup_ph  = apb_req.psel && !apb_req.penable;
  assign access_ph = apb_req.psel && apb_req.penable;
  assign sel       = decode(apb_req.paddr);

  // Source 0 is set by software and comes from this clock domain.
  assign active[0] = st_q.sw_set;

  genvar g;
  generate
    for (g = 1; g < NUM_SRC; g++)
    begin : g_pin
      request_detect u_det
      (
        .clock        (clock),
        .resetn       (resetn),
        .pin          (external_request[g]),
        .active_state (st_q.cfg[g].active_state),
        .active       (active[g])
      );
    end
    for (g = 0; g < NUM_SRC; g++)
    begin : g_route
      source_route u_route
      (
        .cfg       (st_q.cfg[g]),
        .active    (active[g]),
        .int_req   (int_req[g]),
        .int_level (int_level[g]),
        .dma_req   (chan_req[g])
      );
    end
  endgenerate

  always_comb
  begin
    dma_req = '0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      dma_req = dma_req | chan_req[i];
    end
  end

  // A new request of any source, interrupt or DMA, is an event.
  assign event_set = active & ~st_q.act_prev;

  always_comb
  begin
    st_d          = st_q;
    st_d.act_prev = active;
    // Read data is captured in the setup phase so that it comes from a flop.
    if (setup_ph)
    begin
      case (sel)
        SEL_CONFIG: st_d.rdata = cfg_word(st_q.cfg);
        SEL_SWREQ:  st_d.rdata = {31'h0, st_q.sw_set};
        SEL_STATUS: st_d.rdata = {28'h0, st_q.status};
        SEL_MASK:   st_d.rdata = {28'h0, st_q.mask};
        SEL_PEND:   st_d.rdata = {28'h0, active};
        default:    st_d.rdata = 32'h0;
      endcase
    end
    if (access_ph && apb_req.pwrite)
    begin
      case (sel)
        SEL_CONFIG:
        begin
          for (int i = 0; i < NUM_SRC; i++)
          begin
            st_d.cfg[i] = cfg_byte(apb_req.pwdata[SRC_STRIDE*i +: 8]);
          end
        end
        SEL_SWREQ: st_d.sw_set = apb_req.pwdata[0];
        SEL_MASK:  st_d.mask = apb_req.pwdata[NUM_SRC-1:0];
        default:   st_d.sw_set = st_q.sw_set;
      endcase
    end
    // Only the bits that were reported are cleared, and a new event wins.
    if (access_ph && !apb_req.pwrite && sel == SEL_STATUS)
    begin
      st_d.status = st_q.status & ~st_q.rdata[NUM_SRC-1:0];
    end
    st_d.status = st_d.status | event_set;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q.cfg      <= {NUM_SRC{CFG_RST}};
      st_q.sw_set   <= SWREQ_RST;
      st_q.status   <= STATUS_RST;
      st_q.mask     <= MASK_RST;
      // Starting high hides a level already present at reset, so it is not taken as an event.
      st_q.act_prev <= '1;
      st_q.rdata    <= 32'h0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign irq             = |(st_q.status & st_q.mask);
  assign apb_rsp.prdata  = st_q.rdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = access_ph && (sel == SEL_NONE);

  // Checks.
  logic [NUM_SRC-1:0] dma_sel;
  logic [NUM_SRC-1:0] lvl_off;

  always_comb
  begin
    for (int i = 0; i < NUM_SRC; i++)
    begin
      dma_sel[i] = st_q.cfg[i].dma_trigger_sel;
      lvl_off[i] = st_q.cfg[i].level_or_channel_field == LVL_OFF;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  AST_CFG_WRITE: assert property (
    access_ph && apb_req.pwrite && sel == SEL_CONFIG
    |=> cfg_word(st_q.cfg) == ($past(apb_req.pwdata) & 32'h77777777))
    else $error("Source settings do not match the written word.");

  AST_LEVEL_OUT: assert property (
    !st_q.cfg[1].dma_trigger_sel && int_req[1]
    |-> int_level[1] == st_q.cfg[1].level_or_channel_field && int_level[1] != LVL_OFF)
    else $error("Interrupt level of source 1 is not its level field.");

  AST_DISABLED: assert property (
    (int_req & (lvl_off | dma_sel)) == '0)
    else $error("A disabled or DMA source raised an interrupt request.");

  AST_DMA_ROLE: assert property (
    (dma_sel == '0) |-> dma_req == '0)
    else $error("DMA request raised with no source in the DMA role.");

  AST_DMA_CHAN: assert property (
    st_q.sw_set && st_q.cfg[0].dma_trigger_sel
    |-> dma_req[st_q.cfg[0].level_or_channel_field])
    else $error("Software source did not trigger its DMA channel.");

  AST_HIGH_LEVEL: assert property (
    (st_q.cfg[1] == {ACT_HIGH, 1'b0, 3'h5} && external_request[1])[*4]
    |-> ##[1:2] int_req[1])
    else $error("High level on source 1 was not detected in time.");

  AST_RISE_PULSE: assert property (
    st_q.cfg[3].active_state == ACT_RISE && int_req[3] && $stable(st_q.cfg[3])
    |=> !int_req[3])
    else $error("Rising edge request lasted more than one cycle.");

  AST_RESERVED_ZERO: assert property (
    access_ph && !apb_req.pwrite && sel == SEL_CONFIG
    |-> (apb_rsp.prdata & 32'h88888888) == 32'h0)
    else $error("Unused bit of the settings read back as one.");

  AST_EVENT_STICKY: assert property (
    event_set[0] ##1 (st_q.mask[0] && !access_ph)[*2] |-> irq)
    else $error("Event did not raise the interrupt output.");

  AST_RESET_STATE: assert property (
    $rose(resetn)
    |-> st_q.cfg == '0 && st_q.status == '0 && st_q.mask == '0 && !st_q.sw_set)
    else $error("State after reset is not cleared.");

  AST_CFG_HOLD: assert property (
    !(access_ph && apb_req.pwrite && sel == SEL_CONFIG)
    |=> $stable(st_q.cfg))
    else $error("Source settings changed without a write.");

  AST_CFG_READ: assert property (
    access_ph && !apb_req.pwrite && sel == SEL_CONFIG
    |-> apb_rsp.prdata == cfg_word(st_q.cfg))
    else $error("Settings read back differ from the stored settings.");

  AST_LEVEL_SRC3: assert property (
    !st_q.cfg[3].dma_trigger_sel && int_req[3]
    |-> int_level[3] == st_q.cfg[3].level_or_channel_field && int_level[3] != LVL_OFF)
    else $error("Interrupt level of source 3 is not its level field.");

  AST_SW_SOURCE: assert property (
    !st_q.cfg[0].dma_trigger_sel && st_q.cfg[0].level_or_channel_field != LVL_OFF
    |-> int_req[0] == st_q.sw_set)
    else $error("Software source request does not follow its request bit.");

  AST_FALL_PULSE: assert property (
    st_q.cfg[3].active_state == ACT_FALL && int_req[3] && $stable(st_q.cfg[3])
    |=> !int_req[3])
    else $error("Falling edge request lasted more than one cycle.");

  AST_MASK_WRITE: assert property (
    access_ph && apb_req.pwrite && sel == SEL_MASK
    |=> st_q.mask == $past(apb_req.pwdata[NUM_SRC-1:0]))
    else $error("Mask register did not take the written value.");

  AST_MASK_READ: assert property (
    access_ph && !apb_req.pwrite && sel == SEL_MASK
    |-> apb_rsp.prdata == {28'h0, st_q.mask})
    else $error("Mask register read back a wrong value.");

  AST_SWREQ_WRITE: assert property (
    access_ph && apb_req.pwrite && sel == SEL_SWREQ
    |=> st_q.sw_set == $past(apb_req.pwdata[0]))
    else $error("Software request bit did not take the written value.");

  AST_SWREQ_READ: assert property (
    access_ph && !apb_req.pwrite && sel == SEL_SWREQ
    |-> apb_rsp.prdata == {31'h0, st_q.sw_set})
    else $error("Software request bit read back a wrong value.");

  AST_PEND_READ: assert property (
    access_ph && !apb_req.pwrite && sel == SEL_PEND
    |-> apb_rsp.prdata == {28'h0, $past(active)})
    else $error("Pending read does not show the live request lines.");

  AST_EVENT_SET: assert property (
    event_set != '0
    |=> (st_q.status & $past(event_set)) == $past(event_set))
    else $error("An event was lost from the status register.");

  AST_STATUS_HOLD: assert property (
    !(access_ph && !apb_req.pwrite && sel == SEL_STATUS)
    |=> (st_q.status & $past(st_q.status)) == $past(st_q.status))
    else $error("A status bit cleared without a status read.");

  AST_STATUS_READ: assert property (
    access_ph && !apb_req.pwrite && sel == SEL_STATUS
    |-> (apb_rsp.prdata & ~{28'h0, st_q.status}) == 32'h0)
    else $error("Status read reported a bit that is not set.");

  AST_STATUS_CLEAR: assert property (
    access_ph && !apb_req.pwrite && sel == SEL_STATUS && event_set == '0
    |=> (st_q.status & $past(apb_rsp.prdata[NUM_SRC-1:0])) == '0)
    else $error("A reported status bit was not cleared by the read.");

  AST_UNMAPPED_READ: assert property (
    access_ph && !apb_req.pwrite && sel == SEL_NONE
    |-> apb_rsp.prdata == 32'h0)
    else $error("Read of an unmapped address returned data.");

  COV_DMA_TRIGGER:   cover property (dma_req != '0);
  COV_EDGE_IRQ:      cover property (st_q.cfg[3].active_state == ACT_FALL && int_req[3]);
  COV_STATUS_READ:   cover property (access_ph && !apb_req.pwrite && sel == SEL_STATUS && irq);
  COV_SW_INTERRUPT:  cover property (int_req[0] && irq);
  COV_UNMAPPED_READ: cover property (apb_rsp.pslverr);

endmodule

// *** rtl/source_config_pkg.sv ***
// Shared constants, types and helpers of the interrupt source configuration block.
package source_config_pkg;

  localparam int NUM_SRC  = 4;
  localparam int NUM_CHAN = 8;

  // Register byte addresses on the APB.
  localparam logic [31:0] ADDR_CONFIG = 32'hFFFFE000;
  localparam logic [31:0] ADDR_SWREQ  = 32'hFFFFE040;
  localparam logic [31:0] ADDR_STATUS = 32'hFFFFE044;
  localparam logic [31:0] ADDR_MASK   = 32'hFFFFE048;
  localparam logic [31:0] ADDR_PEND   = 32'hFFFFE04C;

  // Field positions inside one byte-wide source setting.
  localparam int SRC_STRIDE = 8;
  localparam int LVL_LSB    = 0;
  localparam int DMA_BIT    = 4;
  localparam int ACT_LSB    = 5;

  // Active state codes.
  localparam logic [1:0] ACT_LOW  = 2'h0;
  localparam logic [1:0] ACT_HIGH = 2'h1;
  localparam logic [1:0] ACT_FALL = 2'h2;
  localparam logic [1:0] ACT_RISE = 2'h3;

  localparam logic [2:0] LVL_OFF    = 3'h0;
  localparam logic [7:0] CHAN_ONE   = 8'h01;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] MASK_RST   = 4'h0;
  localparam logic       SWREQ_RST  = 1'b0;

  typedef struct packed {
    logic [1:0] active_state;
    logic       dma_trigger_sel;
    logic [2:0] level_or_channel_field;
  } src_cfg_t;

  localparam src_cfg_t CFG_RST = '0;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef enum logic [2:0] {SEL_NONE, SEL_CONFIG, SEL_SWREQ, SEL_STATUS, SEL_MASK, SEL_PEND} reg_sel_t;

  function automatic reg_sel_t decode(input logic [31:0] addr);
    case (addr)
      ADDR_CONFIG: decode = SEL_CONFIG;
      ADDR_SWREQ:  decode = SEL_SWREQ;
      ADDR_STATUS: decode = SEL_STATUS;
      ADDR_MASK:   decode = SEL_MASK;
      ADDR_PEND:   decode = SEL_PEND;
      default:     decode = SEL_NONE;
    endcase
  endfunction

  // Unused bit positions come back as zero.
  function automatic logic [31:0] cfg_word(input src_cfg_t [NUM_SRC-1:0] c);
    cfg_word = '0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      cfg_word[SRC_STRIDE*i+ACT_LSB +: 2] = c[i].active_state;
      cfg_word[SRC_STRIDE*i+DMA_BIT]      = c[i].dma_trigger_sel;
      cfg_word[SRC_STRIDE*i+LVL_LSB +: 3] = c[i].level_or_channel_field;
    end
  endfunction

  function automatic src_cfg_t cfg_byte(input logic [7:0] b);
    cfg_byte.active_state           = b[ACT_LSB +: 2];
    cfg_byte.dma_trigger_sel        = b[DMA_BIT];
    cfg_byte.level_or_channel_field = b[LVL_LSB +: 3];
  endfunction

endpackage

// *** rtl/request_detect.sv ***
// Synchroniser and active state detector for one hardware request pin.
`timescale 1ns/100ps
module request_detect
  import source_config_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       pin,
  input  wire logic [1:0] active_state,
  output logic            active
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic filt;
    logic prev;
  } det_t;

  det_t st_q;
  det_t st_d;

  always_comb
  begin
    st_d      = st_q;
    st_d.s1   = pin;
    st_d.s2   = st_q.s1;
    st_d.s3   = st_q.s2;
    st_d.prev = st_q.filt;
    if (st_q.s2 == st_q.s3)
    begin
      st_d.filt = st_q.s3;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  always_comb
  begin
    case (active_state)
      ACT_LOW:  active = ~st_q.filt;
      ACT_HIGH: active = st_q.filt;
      ACT_FALL: active = st_q.prev & ~st_q.filt;
      ACT_RISE: active = ~st_q.prev & st_q.filt;
      default:  active = 1'b0;
    endcase
  end

endmodule

// *** rtl/source_route.sv ***
// Steers one source's request to the priority logic or to a DMA channel.
`timescale 1ns/100ps
module source_route
  import source_config_pkg::*;
(
  input  source_config_pkg::src_cfg_t cfg,
  input  wire logic                   active,
  output logic                        int_req,
  output logic [2:0]                  int_level,
  output logic [NUM_CHAN-1:0]         dma_req
);

  always_comb
  begin
    int_level = cfg.level_or_channel_field;
    int_req   = 1'b0;
    dma_req   = '0;
    if (cfg.dma_trigger_sel)
    begin
      if (active)
      begin
        dma_req = CHAN_ONE << cfg.level_or_channel_field;
      end
    end
    else
    begin
      int_req = active && (cfg.level_or_channel_field != LVL_OFF);
    end
  end

endmodule

// *** verification/request_sink.sv ***
// Core side model that counts the cycles each interrupt request is held.
`timescale 1ns/100ps
module request_sink
  import source_config_pkg::*;
(
  input  wire logic                                clock,
  input  wire logic                                resetn,
  input  wire logic                                clear,
  input  wire logic [source_config_pkg::NUM_SRC-1:0] int_req,
  output logic [source_config_pkg::NUM_SRC-1:0][7:0] high_count
);
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      high_count <= '0;
    else
      for (int i = 0; i < NUM_SRC; i++)
        high_count[i] <= clear ? 8'h00 : high_count[i] + {7'h00, int_req[i]};
  end
endmodule

// *** verification/interrupt_source_config_tb.sv ***
// Self-checking bench for the interrupt source configuration block.
`timescale 1ns/100ps
module interrupt_source_config_tb;
  import source_config_pkg::*;
  logic                         clock;
  logic                         resetn;
  apb_req_t                     apb_req;
  apb_rsp_t                     apb_rsp;
  logic [NUM_SRC-1:1]           external_request;
  logic [NUM_SRC-1:0]           int_req;
  logic [NUM_SRC-1:0][2:0]      int_level;
  logic [NUM_CHAN-1:0]          dma_req;
  logic                         irq;
  logic                         clear;
  logic [NUM_SRC-1:0][7:0]      high_count;
  logic [12:0]                  obs;
  logic [31:0]                  rd;
  logic                         err;
  int                           err_count;
  int                           checks;

  assign obs = {irq, dma_req, int_req};

  interrupt_source_config u_dut (.clock(clock), .resetn(resetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .external_request(external_request), .int_req(int_req),
    .int_level(int_level), .dma_req(dma_req), .irq(irq));

  request_sink u_sink (.clock(clock), .resetn(resetn), .clear(clear), .int_req(int_req),
    .high_count(high_count));

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic report_and_stop();
    $display("err_count=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge clock);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (apb_rsp.pready !== 1'b1)
    begin
      err_count++;
      report_and_stop();
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  // Waits a bounded time for one watched output bit, then judges it.
  task automatic wait_obs(input int b, input logic v);
    int n;
    n = 0;
    while (obs[b] !== v && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    chk({31'h0, obs[b]}, {31'h0, v});
    if (obs[b] !== v)
    begin
      report_and_stop();
    end
  endtask

  task automatic s_reset();
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ADDR_CONFIG, 32'hFFFFFFFF);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk(rd, 32'h77777777);
    chk({20'h0, int_level}, 32'hFFF);
    apb(1'b1, ADDR_CONFIG, 32'h0);
  endtask

  task automatic s_level();
    apb(1'b1, ADDR_MASK, 32'h2);
    apb(1'b1, ADDR_CONFIG, 32'h2500);
    wait_obs(1, 1'b1);
    chk({29'h0, int_level[1]}, 32'h5);
    chk({24'h0, dma_req}, 32'h0);
    wait_obs(12, 1'b1);
    apb(1'b0, ADDR_MASK, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, ADDR_PEND, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, ADDR_MASK, 32'h0);
    wait_obs(12, 1'b0);
    apb(1'b1, ADDR_MASK, 32'h2);
    wait_obs(12, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h2);
    wait_obs(12, 1'b0);
    @(posedge clock);
    external_request[1] <= 1'b0;
    wait_obs(1, 1'b0);
    apb(1'b1, ADDR_CONFIG, 32'h2000);
    @(posedge clock);
    external_request[1] <= 1'b1;
    repeat (10) @(negedge clock);
    chk({31'h0, int_req[1]}, 32'h0);
  endtask

  task automatic s_route();
    logic [3:0] i;
    apb(1'b1, ADDR_MASK, 32'h1);
    for (int k = 1; k < 16; k++)
    begin
      i = k[3:0];
      apb(1'b1, ADDR_CONFIG, {27'h0, i[3], 1'b0, i[2:0]});
      apb(1'b1, ADDR_SWREQ, 32'h1);
      wait_obs(i[3] ? 4 + i[2:0] : 0, 1'b1);
      wait_obs(12, 1'b1);
      apb(1'b0, ADDR_SWREQ, 32'h0);
      chk(rd, 32'h1);
      chk({29'h0, int_level[0]}, {29'h0, i[2:0]});
      chk({24'h0, dma_req}, i[3] ? 32'h1 << i[2:0] : 32'h0);
      chk({31'h0, int_req[0]}, {31'h0, ~i[3]});
      apb(1'b1, ADDR_SWREQ, 32'h0);
    end
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h3);
    wait_obs(12, 1'b0);
  endtask

  task automatic s_edge();
    for (int m = 2; m < 4; m++)
    begin
      @(posedge clock);
      external_request[3] <= (m == 2);
      repeat (8) @(posedge clock);
      apb(1'b1, ADDR_CONFIG, {1'b0, m[1:0], 5'h03, 24'h0});
      repeat (8) @(posedge clock);
      clear <= 1'b1;
      @(posedge clock);
      clear <= 1'b0;
      external_request[3] <= (m != 2);
      repeat (12) @(negedge clock);
      chk({24'h0, high_count[3]}, 32'h1);
    end
    apb(1'b1, ADDR_CONFIG, 32'h03000000);
    @(posedge clock);
    external_request[3] <= 1'b0;
    wait_obs(3, 1'b1);
    apb(1'b0, 32'hFFFFE050, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask

  initial
  begin
    apb_req          = '0;
    external_request = 3'h7;
    clear            = 1'b0;
    resetn           = 1'b0;
    err_count        = 0;
    checks           = 0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    s_reset();
    s_level();
    s_route();
    s_edge();
    report_and_stop();
  end
endmodule
